// >>> core/hsdp_lpf.v
/*
 * first-order digital low-pass on the converter value, one step per enable.
 * assumes en is a one-cycle pulse at the sample rate and din is held at it.
 */
`include "hsdp_regs.vh"

module hsdp_lpf #(
    parameter W    = 16,
    parameter FRAC = `HSDP_LP_FRAC
) (
    // clock and reset
    input  wire                clk,
    input  wire                rst,
    // control
    input  wire                en,
    input  wire [2:0]          sel,
    // data
    input  wire signed [W-1:0] din,
    output reg  signed [W-1:0] dout
);

    reg  signed [W+FRAC-1:0] acc_reg;
    wire signed [W+FRAC:0]   diff;
    wire signed [W+FRAC:0]   step;
    reg  signed [W+FRAC-1:0] acc_next;

    function [3:0] shift_of;
        input [2:0] s;
        begin
            case (s)
                3'h0:    shift_of = 4'h8;
                3'h1:    shift_of = 4'h6;
                3'h2:    shift_of = 4'h5;
                3'h3:    shift_of = 4'h5;
                3'h4:    shift_of = 4'h4;
                3'h5:    shift_of = 4'h4;
                3'h6:    shift_of = 4'h3;
                default: shift_of = 4'h0;
            endcase
        end
    endfunction

    assign diff = $signed({din[W-1], din, {FRAC{1'b0}}}) - $signed({acc_reg[W+FRAC-1], acc_reg});
    // arithmetic shift kept apart so a negative step stays negative
    assign step = diff >>> shift_of(sel);

    // step toward input; shift keeps dc gain at one
    always @* begin
        acc_next = acc_reg;
        if (sel == `HSDP_LP_BYPASS) begin
            acc_next = {din, {FRAC{1'b0}}};
        end else begin
            acc_next = acc_reg + step[W+FRAC-1:0];
        end
    end

    always @(posedge clk) begin
        if (rst) begin
            acc_reg <= {(W+FRAC){1'b0}};
            dout    <= {W{1'b0}};
        end else if (en) begin
            acc_reg <= acc_next;
            dout    <= acc_next[W+FRAC-1:FRAC];
        end
    end

endmodule

// >>> core/hsdp_path.v
/*
 * hall signal path: sample tick, filter, compensated gain, offset,
 * 16-bit limiter, clamping, diagnostics and stored-line parity repair.
 * assumes all inputs synchronous to clk and configuration quasi-static.
 */
// How it works
// - range field 3 low, 1 mid, 0 high
// - range code 2 acts as code 1
// - gain equals (code minus 16384) over 4096
// - offset equals code minus 16384, 12-bit units
// - offset added after multiplier, before limiter
// - limit sum to 16 bits, hand onward
// - 3-bit filter select, code 7 bypasses
// - filter keeps unity dc gain always
// - new filtered sample at 16 kHz
// - temperature minus reference before polynomial
// - linear term is difference times slope
// - quadratic term is difference squared times curvature
// - terms summed, times gain, form multiplier
// - out of bounds output holds clamp bound
// - low bound code times 512, 0 off
// - high bound (code+1)*512-1, 127 off
// - high bound wins over low bound
// - diagnostics reported through status nibble
// - overvoltage sets status bit, driver off
// - repair one bad line, detect second
// - unrepairable line disables driver permanently
// - slope (code-160)/65536, curvature (code-128)/8388608
`include "hsdp_regs.vh"

module hsdp_path #(
    parameter LINES = 8,
    parameter WIDTH = 16
) (
    // clock and reset
    input  wire                   clk,
    input  wire                   rst,
    // converter inputs
    input  wire signed [15:0]     adc_sample,
    input  wire signed [7:0]      temp_value,
    // configuration
    input  wire [1:0]             range_code,
    input  wire [14:0]            gain_code,
    input  wire [14:0]            offset_code,
    input  wire [2:0]             filter_select,
    input  wire [6:0]             lower_limit_code,
    input  wire [6:0]             upper_limit_code,
    input  wire signed [7:0]      reference_temperature,
    input  wire [8:0]             linear_coeff_code,
    input  wire [7:0]             quadratic_coeff_code,
    // diagnostics in
    input  wire                   overvoltage,
    input  wire [LINES*WIDTH-1:0] mem_rows,
    input  wire [LINES-1:0]       mem_row_par,
    input  wire [WIDTH-1:0]       mem_col_par,
    // processed output
    output reg  [1:0]             range_sel,
    output reg                    sample_tick,
    output reg  [15:0]            out_value,
    output reg                    out_valid,
    output reg  [3:0]             status_nibble,
    output reg                    driver_off,
    output reg  [LINES*WIDTH-1:0] mem_fixed
);

    localparam integer TICK_CYCLES = `HSDP_TICK_CYCLES;
    localparam [10:0]  TICK_LAST   = TICK_CYCLES[10:0] - 11'h001;

    reg  [10:0]         tick_cnt_reg;
    reg                 tick_reg;
    reg                 p1_reg;
    reg                 p2_reg;
    reg  signed [22:0]  mult_reg;
    reg  [15:0]         sat_reg;
    reg                 defect_reg;
    wire signed [15:0]  filt;

    // ---- sample rate ----
    always @(posedge clk) begin
        if (rst) begin
            tick_cnt_reg <= 11'h000;
            tick_reg     <= 1'b0;
        end else if (tick_cnt_reg == TICK_LAST) begin
            tick_cnt_reg <= 11'h000;
            tick_reg     <= 1'b1;
        end else begin
            tick_cnt_reg <= tick_cnt_reg + 11'h001;
            tick_reg     <= 1'b0;
        end
    end

    hsdp_lpf #(
        .W    (16),
        .FRAC (`HSDP_LP_FRAC)
    ) u_lpf (
        .clk  (clk),
        .rst  (rst),
        .en   (tick_reg),
        .sel  (filter_select),
        .din  (adc_sample),
        .dout (filt)
    );

    // ---- range ----
    always @(posedge clk) begin
        if (rst) begin
            range_sel <= `HSDP_RANGE_MID;
        end else if (range_code == `HSDP_RANGE_UNUSED) begin
            range_sel <= `HSDP_RANGE_MID;
        end else begin
            range_sel <= range_code;
        end
    end

    // 15-bit code to signed value about its zero point
    function signed [15:0] centre15;
        input [14:0] code;
        input [15:0] zero;
        begin
            centre15 = $signed({1'b0, code}) - $signed(zero);
        end
    endfunction

    // ---- temperature compensation ----
    wire signed [9:0]  dt;
    wire signed [9:0]  tl_s;
    wire signed [8:0]  tq_s;
    wire signed [19:0] lin;
    wire signed [19:0] sq;
    wire signed [28:0] quad;
    wire signed [29:0] stc;
    wire signed [15:0] gain_s;
    wire signed [45:0] mult_full;

    assign dt   = $signed({{2{temp_value[7]}}, temp_value})
                - $signed({{2{reference_temperature[7]}}, reference_temperature});
    assign tl_s = $signed({1'b0, linear_coeff_code}) - `HSDP_TL_ZERO;
    assign tq_s = $signed({1'b0, quadratic_coeff_code}) - `HSDP_TQ_ZERO;
    assign lin  = dt * tl_s;
    assign sq   = dt * dt;
    assign quad = sq * tq_s;
    // unity at 2^23; linear scale 2^16 lifted by 2^7
    assign stc  = `HSDP_STC_ONE
                + $signed({{3{lin[19]}}, lin, 7'h00})
                + $signed({quad[28], quad});
    assign gain_s    = centre15(gain_code, `HSDP_GAIN_ZERO);
    assign mult_full = stc * gain_s;

    always @(posedge clk) begin
        if (rst) begin
            mult_reg <= 23'h000000;
        end else begin
            mult_reg <= mult_full[45:`HSDP_STC_FRAC];
        end
    end

    // ---- multiplier, offset, limiter ----
    wire signed [38:0] prod;
    wire signed [26:0] scaled;
    wire signed [15:0] ofs_s;
    wire signed [27:0] sum;

    assign prod   = filt * mult_reg;
    assign scaled = prod[38:`HSDP_GAIN_FRAC];
    assign ofs_s  = centre15(offset_code, `HSDP_OFFSET_ZERO);
    assign sum    = $signed({scaled[26], scaled})
                  + $signed({{8{ofs_s[15]}}, ofs_s, 4'h0});

    function [15:0] limit16;
        input signed [27:0] v;
        begin
            if (v < 0) begin
                limit16 = 16'h0000;
            end else if (v > $signed({12'h000, `HSDP_OUT_MAX})) begin
                limit16 = `HSDP_OUT_MAX;
            end else begin
                limit16 = v[15:0];
            end
        end
    endfunction

    // ---- clamping ----
    wire [15:0] lo_bound;
    wire [15:0] hi_bound;
    reg  [15:0] clamp_lo;
    reg  [15:0] clamp_out;

    // clamp code to bound; the off code opens that side fully
    function [15:0] clamp_bound;
        input [6:0]  code;
        input        upper;
        reg   [16:0] full;
        begin
            if (upper) begin
                full        = ({10'h000, code} + 17'h00001) * `HSDP_CLAMP_STEP - 17'h00001;
                clamp_bound = (code == `HSDP_CH_OFF) ? `HSDP_OUT_MAX : full[15:0];
            end else begin
                full        = {10'h000, code} * `HSDP_CLAMP_STEP;
                clamp_bound = (code == `HSDP_CL_OFF) ? 16'h0000 : full[15:0];
            end
        end
    endfunction

    assign lo_bound = clamp_bound(lower_limit_code, 1'b0);
    assign hi_bound = clamp_bound(upper_limit_code, 1'b1);

    // high bound applied last so it dominates
    always @* begin
        clamp_lo  = (sat_reg < lo_bound) ? lo_bound : sat_reg;
        clamp_out = (clamp_lo > hi_bound) ? hi_bound : clamp_lo;
    end

    // ---- pipeline ----
    always @(posedge clk) begin
        if (rst) begin
            p1_reg      <= 1'b0;
            p2_reg      <= 1'b0;
            sat_reg     <= 16'h0000;
            out_value   <= 16'h0000;
            out_valid   <= 1'b0;
            sample_tick <= 1'b0;
        end else begin
            p1_reg      <= tick_reg;
            p2_reg      <= p1_reg;
            sample_tick <= p1_reg;
            out_valid   <= p2_reg;
            if (p1_reg) begin
                sat_reg <= limit16(sum);
            end
            if (p2_reg) begin
                out_value <= clamp_out;
            end
        end
    end

    // ---- stored line parity ----
    reg [LINES-1:0] row_bad;
    reg [WIDTH-1:0] col_bad;
    reg [3:0]       bad_rows;
    reg [3:0]       bad_cols;
    reg             col_sum;
    reg [LINES*WIDTH-1:0] fixed;
    integer r;
    integer c;

    // rows odd; even columns even, odd columns odd
    always @* begin
        row_bad  = {LINES{1'b0}};
        col_bad  = {WIDTH{1'b0}};
        bad_rows = 4'h0;
        bad_cols = 4'h0;
        col_sum  = 1'b0;
        fixed    = mem_rows;
        for (r = 0; r < LINES; r = r + 1) begin
            row_bad[r] = ~(^mem_rows[r*WIDTH +: WIDTH] ^ mem_row_par[r]);
            bad_rows   = bad_rows + {3'h0, row_bad[r]};
        end
        for (c = 0; c < WIDTH; c = c + 1) begin
            col_sum = mem_col_par[c];
            for (r = 0; r < LINES; r = r + 1) begin
                col_sum = col_sum ^ mem_rows[r*WIDTH + c];
            end
            col_bad[c] = col_sum ^ c[0];
            bad_cols   = bad_cols + {3'h0, col_bad[c]};
        end
        if (bad_rows == 4'h1 && bad_cols == 4'h1) begin
            for (r = 0; r < LINES; r = r + 1) begin
                for (c = 0; c < WIDTH; c = c + 1) begin
                    if (row_bad[r] && col_bad[c]) begin
                        fixed[r*WIDTH + c] = ~mem_rows[r*WIDTH + c];
                    end
                end
            end
        end
    end

    always @(posedge clk) begin
        if (rst) begin
            mem_fixed  <= {LINES*WIDTH{1'b0}};
            defect_reg <= 1'b0;
        end else begin
            mem_fixed <= fixed;
            if (bad_rows > 4'h1) begin
                defect_reg <= 1'b1;
            end
        end
    end

    // ---- diagnostics ----
    always @(posedge clk) begin
        if (rst) begin
            status_nibble <= 4'h0;
            driver_off    <= 1'b0;
        end else begin
            status_nibble[`HSDP_ST_OV]     <= overvoltage;
            status_nibble[`HSDP_ST_DEFECT] <= defect_reg | (bad_rows > 4'h1);
            status_nibble[`HSDP_ST_FIXED]  <= (bad_rows == 4'h1);
            status_nibble[3]               <= 1'b0;
            driver_off <= overvoltage | defect_reg | (bad_rows > 4'h1);
        end
    end

endmodule

// >>> core/hsdp_regs.vh
/*
 * constants of the hall signal path: code zero points, clamp steps,
 * compensation scaling and the sample rate divider.
 * assumes inclusion by bare name from the core files only.
 */
`ifndef HSDP_REGS_VH
`define HSDP_REGS_VH

// clock and sample rate
`define HSDP_CLK_HZ         20000000
`define HSDP_SAMPLE_HZ      16000
`define HSDP_TICK_CYCLES    (`HSDP_CLK_HZ / `HSDP_SAMPLE_HZ)

// range codes
`define HSDP_RANGE_HIGH     2'h0
`define HSDP_RANGE_MID      2'h1
`define HSDP_RANGE_UNUSED   2'h2
`define HSDP_RANGE_LOW      2'h3

// code zero points
`define HSDP_GAIN_ZERO      16'sh4000
`define HSDP_OFFSET_ZERO    16'sh4000
`define HSDP_TL_ZERO        10'sh0a0
`define HSDP_TQ_ZERO        9'sh080

// compensation: unity at 2^23, linear term scaled by 2^7 to meet it
`define HSDP_STC_ONE        30'sh0800000
`define HSDP_LIN_SHIFT      7
`define HSDP_STC_FRAC       23
`define HSDP_GAIN_FRAC      12

// offset is in 12-bit units, output in 16-bit units
`define HSDP_OFS_SHIFT      4

// clamping
`define HSDP_CLAMP_STEP     17'h00200
`define HSDP_CL_OFF         7'h00
`define HSDP_CH_OFF         7'h7f
`define HSDP_OUT_MAX        16'hffff

// filter
`define HSDP_LP_BYPASS      3'h7
`define HSDP_LP_FRAC        8

// status nibble bits
`define HSDP_ST_OV          0
`define HSDP_ST_DEFECT      1
`define HSDP_ST_FIXED       2

`endif

// >>> sim/hsdp_path_sva.sv
/*
 * port checker for hsdp_path.
 * assumes config held steady around sample ticks.
 */
module hsdp_path_sva (
    // clock and reset
    input wire        clk,
    input wire        rst,
    // inputs
    input wire [1:0]  range_code,
    input wire [6:0]  lower_limit_code,
    input wire [6:0]  upper_limit_code,
    input wire        overvoltage,
    // outputs
    input wire [1:0]  range_sel,
    input wire        sample_tick,
    input wire [15:0] out_value,
    input wire        out_valid,
    input wire [3:0]  status_nibble,
    input wire        driver_off
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [11:0] gap_reg;
    logic        seen_reg;
    // cycles since last frame
    always @(posedge clk) begin
        if (rst) begin
            gap_reg  <= 12'h000;
            seen_reg <= 1'b0;
        end else begin
            gap_reg  <= out_valid ? 12'h000 : gap_reg + 12'h001;
            seen_reg <= seen_reg | out_valid;
        end
    end
    default clocking dc @(posedge clk);
    endclocking
    default disable iff (rst);
    a_range_fold: assert property (
        $stable(range_code) [*3] |-> range_sel == (range_code == 2'h2 ? 2'h1 : range_code))
        else $error("range_sel wrong");
    a_frame_period: assert property (seen_reg |-> out_valid == (gap_reg == 12'h4e1))
        else $error("frame spacing wrong");
    a_tick_valid: assert property (!$past(rst) |-> out_valid == $past(sample_tick))
        else $error("out_valid not after sample_tick");
    a_value_holds: assert property (!out_valid && !$past(rst) |-> $stable(out_value))
        else $error("out_value moved between frames");
    a_ov_status: assert property (
        !$past(rst) |-> status_nibble[0] == $past(overvoltage) && !status_nibble[3])
        else $error("status nibble overvoltage bit wrong");
    a_ov_off: assert property (overvoltage |=> driver_off)
        else $error("driver on during overvoltage");
    a_defect_hold: assert property (status_nibble[1] |=> status_nibble[1] && driver_off)
        else $error("defect not sticky");
    a_off_cause: assert property (
        !$past(rst) && !$past(overvoltage) && !status_nibble[1] |-> !driver_off)
        else $error("driver off without cause");
    a_clamp_high: assert property (out_valid |-> out_value <= {upper_limit_code, 9'h1ff})
        else $error("above upper clamp");
    a_clamp_low: assert property (
        out_valid && upper_limit_code >= lower_limit_code |-> out_value >= {lower_limit_code, 9'h000})
        else $error("below lower clamp");
endmodule

bind hsdp_path hsdp_path_sva u_sva (
    .clk, .rst, .range_code, .lower_limit_code, .upper_limit_code, .overvoltage,
    .range_sel, .sample_tick, .out_value, .out_valid, .status_nibble, .driver_off
);

// >>> sim/hsdp_path_tb.sv
/*
 * self-checking bench for hsdp_path with the receiver model.
 * assumes 20 MHz clock; config changes just after a frame.
 */
module hsdp_path_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic               clk = 1'b0;
    logic               rst = 1'b1;
    logic               overvoltage = 1'b0;
    logic signed [15:0] adc_sample = 16'sh0000;
    logic signed [7:0]  temp_value = 8'sh04;
    logic signed [7:0]  reference_temperature = 8'sh04;
    logic [1:0]         range_code = 2'h1;
    logic [14:0]        gain_code = 15'h5000;
    logic [14:0]        offset_code = 15'h4000;
    logic [2:0]         filter_select = 3'h7;
    logic [6:0]         lower_limit_code = 7'h00;
    logic [6:0]         upper_limit_code = 7'h7f;
    logic [8:0]         linear_coeff_code = 9'h0a0;
    logic [7:0]         quadratic_coeff_code = 8'h80;
    logic [127:0]       mem_rows;
    logic [7:0]         mem_row_par;
    logic [15:0]        mem_col_par;
    logic [127:0]       good_rows;
    logic [95:0]        rv;
    wire [1:0]          range_sel;
    wire                sample_tick;
    wire [15:0]         out_value;
    wire                out_valid;
    wire [3:0]          status_nibble;
    wire                driver_off;
    wire [127:0]        mem_fixed;
    wire [15:0]         rx_value;
    wire [3:0]          rx_status;
    int                 n_errors = 0;
    int                 tests_run = 0;

    always #25 clk = ~clk;

    hsdp_path dut (.clk, .rst, .adc_sample, .temp_value, .range_code, .gain_code, .offset_code, .filter_select,
        .lower_limit_code, .upper_limit_code, .reference_temperature, .linear_coeff_code, .quadratic_coeff_code,
        .overvoltage, .mem_rows, .mem_row_par, .mem_col_par, .range_sel, .sample_tick, .out_value, .out_valid,
        .status_nibble, .driver_off, .mem_fixed);
    hsdp_rx_model rx (.clk, .rst, .out_value, .out_valid, .status_nibble, .driver_off, .rx_value, .rx_status);

    task automatic check(input logic [127:0] seen, input logic [127:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d errors %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // stored lines with valid parity, optional bit flips
    task automatic set_mem(input logic [127:0] flip);
        mem_rows = good_rows ^ flip;
        mem_col_par = 16'haaaa;
        for (int r = 0; r < 8; r++) begin
            mem_row_par[r] = ~^good_rows[r*16 +: 16];
            mem_col_par = mem_col_par ^ good_rows[r*16 +: 16];
        end
    endtask

    task automatic wait_frame();
        int n;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (out_valid !== 1'b1 && n < 3000);
        @(negedge clk); // receiver latches the frame on the next edge
        check(n < 3000, 1'b1);
    endtask

    function automatic logic [15:0] exp_out(longint x, longint g, longint os, longint s, longint lo, longint hi);
        longint v;
        v = ((x * (g - 16384) * s) >>> 35) + (os - 16384) * 16;
        if (v < 0) v = 0;
        if (v > 65535) v = 65535;
        if (lo != 0 && v < lo * 512) v = lo * 512;
        if (hi != 127 && v > hi * 512 + 511) v = hi * 512 + 511;
        return v[15:0];
    endfunction

    task automatic run(input logic [15:0] x, input logic [14:0] g, input logic [14:0] os, input logic [6:0] lo,
                       input logic [6:0] hi, input logic [7:0] t, input logic [8:0] tl, input logic [7:0] tq);
        longint d;
        longint s;
        adc_sample = x;
        gain_code = g;
        offset_code = os;
        lower_limit_code = lo;
        upper_limit_code = hi;
        temp_value = t;
        linear_coeff_code = tl;
        quadratic_coeff_code = tq;
        wait_frame();
        d = longint'($signed(t)) - longint'(reference_temperature);
        s = 8388608 + (longint'(tl) - 160) * d * 128 + (longint'(tq) - 128) * d * d;
        check({rx_status, rx_value}, {4'h0, exp_out($signed(x), g, os, s, lo, hi)});
    endtask

    initial begin
        void'($urandom(14784));
        good_rows = {$urandom, $urandom, $urandom, $urandom};
        set_mem(128'h0);
        repeat (4) @(negedge clk);
        rst = 1'b0;
        for (int r = 0; r < 4; r++) begin
            range_code = 2'(r);
            repeat (5) @(negedge clk);
            check(range_sel, (r == 2) ? 2'h1 : 2'(r));
        end
        range_code = 2'h1; // range fixed before gain and offset runs
        $display("range test done");
        wait_frame();
        run(16'h1000, 15'h5000, 15'h4000, 7'h00, 7'h7f, 8'h04, 9'h0a0, 8'h80);
        run(16'h7fff, 15'h7fff, 15'h7fff, 7'h00, 7'h7f, 8'h04, 9'h0a0, 8'h80);
        run(16'h7fff, 15'h0000, 15'h4000, 7'h00, 7'h7f, 8'h04, 9'h0a0, 8'h80);
        run(16'h0100, 15'h5000, 15'h4100, 7'h0a, 7'h14, 8'h04, 9'h0a0, 8'h80);
        run(16'h4000, 15'h5000, 15'h4800, 7'h03, 7'h05, 8'h04, 9'h0a0, 8'h80);
        run(16'h0000, 15'h5000, 15'h4400, 7'h09, 7'h02, 8'h04, 9'h0a0, 8'h80);
        run(16'h0400, 15'h5000, 15'h4000, 7'h00, 7'h7f, 8'h14, 9'h0e0, 8'ha0);
        run(16'h0400, 15'h5000, 15'h4000, 7'h00, 7'h7f, 8'hf4, 9'h0e0, 8'ha0);
        for (int i = 0; i < 10; i++) begin
            rv = {$urandom, $urandom, $urandom};
            run(rv[15:0], rv[30:16], rv[45:31], rv[52:46], rv[59:53], 8'h04, 9'h0a0, 8'h80);
        end
        $display("datapath test done");
        overvoltage = 1'b1;
        repeat (2) @(negedge clk);
        check({status_nibble[0], driver_off}, 2'b11);
        overvoltage = 1'b0;
        repeat (2) @(negedge clk);
        check({status_nibble[0], driver_off}, 2'b00);
        set_mem(128'h1 << 37);
        repeat (3) @(negedge clk);
        check(mem_fixed, good_rows);
        check({status_nibble[2:1], driver_off}, 3'b100);
        set_mem((128'h1 << 37) | (128'h1 << 90));
        repeat (3) @(negedge clk);
        set_mem(128'h0);
        repeat (3) @(negedge clk);
        check({status_nibble[1], driver_off}, 2'b11);
        $display("diagnostics test done");
        rst = 1'b1;
        upper_limit_code = 7'h7f;
        lower_limit_code = 7'h00;
        gain_code = 15'h5000;
        offset_code = 15'h4000;
        temp_value = 8'sh04;
        adc_sample = 16'sh1000;
        filter_select = 3'h6;
        repeat (4) @(negedge clk);
        rst = 1'b0;
        wait_frame();
        check(rx_value > 16'h0000 && rx_value < 16'h1000, 1'b1);
        repeat (40) wait_frame();
        check(rx_value > 16'h0fe0 && rx_value < 16'h1020, 1'b1);
        $display("filter test done");
        print_verdict();
    end

    initial begin
        #5000000;
        n_errors++;
        print_verdict();
    end
endmodule

// >>> sim/hsdp_rx_model.sv
/*
 * receiving protocol stage: latches each frame handed over.
 * assumes frames are lost while the open-drain driver is off.
 */
module hsdp_rx_model (
    // clock and reset
    input  wire         clk,
    input  wire         rst,
    // frame from the path
    input  wire  [15:0] out_value,
    input  wire         out_valid,
    input  wire  [3:0]  status_nibble,
    input  wire         driver_off,
    // latched frame
    output logic [15:0] rx_value,
    output logic [3:0]  rx_status
);
    timeunit 1ns;
    timeprecision 1ns;
    always @(posedge clk) begin
        if (rst) begin
            rx_value  <= 16'h0000;
            rx_status <= 4'h0;
        end else if (out_valid && !driver_off) begin
            rx_value  <= out_value;
            rx_status <= status_nibble;
        end
    end
endmodule
